//--- plr_cal_adder.sv
// Saturating offset adder for current readback and overcurrent limits
`timescale 1ns/10ps
`default_nettype none
module plr_cal_adder #(
	parameter int N = 3
) (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic [10:0]       i_offset,
	input  wire logic [N*16-1:0]   i_val,
	output var  logic [N*16-1:0]   o_val
);

	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;

	logic [15:0] off_ext;

	assign off_ext = {{5{i_offset[10]}}, i_offset};

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_lane
			logic [16:0] sum;
			logic [15:0] res;
			assign sum = {i_val[g*16+15], i_val[g*16 +: 16]} + {off_ext[15], off_ext};
			assign res = (sum[16] != sum[15]) ? (sum[16] ? SAT_NEG : SAT_POS) : sum[15:0];
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					o_val[g*16 +: 16] <= 16'h0000;
				end else begin
					o_val[g*16 +: 16] <= res;
				end
			end
		end
	endgenerate

endmodule : plr_cal_adder
`default_nettype wire

//--- plr_host.sv
// Host model issuing one command word per request
`timescale 1ns/10ps
`default_nettype none
module plr_host (
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic        i_nack,
	input  wire logic [15:0] i_rd,
	output var  logic        o_wr = 1'b0,
	output var  logic        o_rd = 1'b0,
	output var  logic [7:0]  o_code = 8'h00,
	output var  logic [15:0] o_data = 16'h0000
);
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [1:0] an, output logic [15:0] q);
		o_wr <= w;
		o_rd <= !w;
		o_code <= c;
		o_data <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_data <= ~d;
		@(posedge i_clk);
		an = {i_ack, i_nack};
		q = i_rd;
	endtask : xfer
endmodule : plr_host
`default_nettype wire

//--- plr_pkg.sv
// Constants, types and shared decoding for the limit and fault response commands
// Notes on behaviour
// - Out-of-range turn-off threshold write is invalid data: set CML, invalid-data, alert.
// - Rejected turn-off threshold write leaves the held value unchanged.
// - In-range turn-off threshold is rounded to the nearest 0.25 V step.
// - Turn-off mantissa accepts 16 to 30, resets to 16.
// - Turn-on must stay above turn-off; violating writes rejected with flags and alert.
// - Turn-off word has fixed exponent 11110; top four mantissa bits fixed, seven writable.
// - Store-all command copies turn-off, calibration offset and response setting to NVM.
// - Calibration offset corrects current readback and overcurrent fault and warning limits.
// - Calibration offset has 62.5 mA steps, +3.9375 A to -4 A, resets to zero.
// - Offset exponent fixed at 11100; out-of-range writes wrap via read-only bits.
// - Offset mantissa MSB is writable sign, next four copy it, low six writable.
// - Overvoltage fault sets byte, word and vout overvoltage flags and raises alert.
// - Loop follower ignores response command, NACKs access, flags invalid command, alerts.
// - Response byte resets to shutdown with retry after seven rise times; fixed layout.
// - Select 0 keeps regulating but flags and alerts; select 1 shuts down, follows retry.
// - Retry mode 000 stays disabled until faults are cleared.
// - Retry mode 111 retries soft start endlessly until off or other fault.
// - Retry mode other than 000 or 111 is rejected with CML, invalid-data, alert.
// - Only retry mode bit 5 goes to nonvolatile memory.
// - Delay 000 means no delay with retry off; 111 waits seven rise times.
// - Read-only delay bits always mirror retry mode bit 5.
// - Turn-on threshold uses 0.25 V steps, 17 to 31, reset 18, ordering checked.
package plr_pkg;

	// ******************************************************************
	// Command codes
	// ******************************************************************
	localparam logic [7:0] CMD_VIN_ON       = 8'h35;
	localparam logic [7:0] CMD_INPUT_TURNOFF_THRESHOLD      = 8'h36;
	localparam logic [7:0] CMD_IOUT_CAL     = 8'h39;
	localparam logic [7:0] CMD_OV_RESPONSE  = 8'h41;

	// ******************************************************************
	// Threshold words
	// ******************************************************************
	localparam logic [4:0] VIN_EXP          = 5'h1e;
	localparam logic [3:0] VIN_MANT_FIXED   = 4'h0;
	localparam logic [6:0] INPUT_TURNOFF_THRESHOLD_MIN      = 7'h10;
	localparam logic [6:0] INPUT_TURNOFF_THRESHOLD_MAX      = 7'h1e;
	localparam logic [6:0] INPUT_TURNOFF_THRESHOLD_RESET    = 7'h10;
	localparam logic [6:0] VIN_ON_MIN       = 7'h11;
	localparam logic [6:0] VIN_ON_MAX       = 7'h1f;
	localparam logic [6:0] VIN_ON_RESET     = 7'h12;
	localparam int         QTR_EXP_SHIFT    = 2;
	localparam int         QTR_SHIFT_LIMIT  = 8;
	localparam int         QTR_HUGE         = 1024;
	localparam int         QTR_MAX          = 255;

	// ******************************************************************
	// Calibration offset word
	// ******************************************************************
	localparam logic [4:0] CAL_EXP          = 5'h1c;
	localparam int         CAL_SIGN_BIT     = 10;
	localparam int         CAL_LOW_W        = 6;
	localparam int         CAL_EXT_W        = 4;
	localparam logic [5:0] CAL_LOW_RESET    = 6'h00;

	// ******************************************************************
	// Overvoltage response byte
	// ******************************************************************
	localparam int         OVR_SEL_BIT      = 7;
	localparam int         OVR_RS_HI        = 5;
	localparam int         OVR_RS_LO        = 3;
	localparam logic [2:0] OVR_RS_OFF       = 3'h0;
	localparam logic [2:0] OVR_RS_ON        = 3'h7;
	localparam logic       OVR_SEL_RESET    = 1'b1;
	localparam logic       OVR_RS5_RESET    = 1'b1;
	localparam logic [2:0] RETRY_RISES      = 3'h7;

	// ******************************************************************
	// Overvoltage handling states
	// ******************************************************************
	typedef enum logic [1:0] {
		OV_RUN,
		OV_LATCHED,
		OV_RETRY_WAIT
	} plr_ov_state_e;

	// ******************************************************************
	// Linear word to 0.25 V steps, rounded; bit 8 marks unrepresentable
	// ******************************************************************
	function automatic logic [8:0] plr_to_quarters(input logic [15:0] w);
		int e;
		int m;
		int sh;
		int v;
		e  = $signed(w[15:11]);
		m  = $signed(w[10:0]);
		sh = e + QTR_EXP_SHIFT;
		if (sh >= 0) begin
			if (sh > QTR_SHIFT_LIMIT) begin
				v = (m == 0) ? 0 : QTR_HUGE;
			end else begin
				v = m <<< sh;
			end
		end else if (sh < -16) begin
			v = 0;
		end else begin
			v = (m + (1 <<< (-sh - 1))) >>> (-sh);
		end
		if (v < 0 || v > QTR_MAX) begin
			return 9'h100;
		end
		return {1'b0, v[7:0]};
	endfunction : plr_to_quarters

endpackage : plr_pkg

//--- plr_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module plr_sync3 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_d,
	output var  logic [W-1:0] o_q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
					o_q[g]  <= 1'b0;
				end else begin
					s1_r[g] <= i_d[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						o_q[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

endmodule : plr_sync3
`default_nettype wire

//--- plr_top.sv
// Input thresholds, current calibration offset and overvoltage response commands
`timescale 1ns/10ps
`default_nettype none
module plr_top (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_NRST,
	input  wire logic        I_CMD_WR,
	input  wire logic        I_CMD_RD,
	input  wire logic [7:0]  I_CMD_CODE,
	input  wire logic [15:0] I_WR_DATA,
	input  wire logic        I_CLEAR_FAULTS,
	input  wire logic        I_STORE_ALL,
	input  wire logic        I_LOOP_FOLLOWER,
	input  wire logic        I_OV_FAULT,
	input  wire logic        I_OTHER_FAULT,
	input  wire logic        I_OP_ON,
	input  wire logic        I_ALERT_MASK,
	input  wire logic [15:0] I_TON_RISE_CYC,
	input  wire logic [15:0] I_IOUT_MEAS,
	input  wire logic [15:0] I_OC_FAULT_LIM,
	input  wire logic [15:0] I_OC_WARN_LIM,
	output var  logic        O_CMD_ACK,
	output var  logic        O_CMD_NACK,
	output var  logic [15:0] O_RD_DATA,
	output var  logic        O_STATUS_CML,
	output var  logic        O_STATUS_IVD,
	output var  logic        O_STATUS_IVC,
	output var  logic        O_STATUS_OVF,
	output var  logic        O_STATUS_VFW,
	output var  logic        O_STATUS_VOUT_OVF,
	output var  logic        O_SMBALERT_OE,
	output var  logic        O_OUTPUT_EN,
	output var  logic        O_SOFTSTART_REQ,
	output var  logic        O_NVM_WR,
	output var  logic [15:0] O_NVM_DATA,
	output var  logic [15:0] O_IOUT_CORR,
	output var  logic [15:0] O_OC_FAULT_CORR,
	output var  logic [15:0] O_OC_WARN_CORR
);

	// ******************************************************************
	// Declarations
	// ******************************************************************
	logic [6:0]                 input_turnoff_threshold_r;
	logic [6:0]                 vin_on_r;
	logic                       cal_sign_r;
	logic [5:0]                 cal_low_r;
	logic                       ovr_sel_r;
	logic                       ovr_rs5_r;
	logic                       flg_cml_r;
	logic                       flg_ivd_r;
	logic                       flg_ivc_r;
	logic                       flg_ovf_r;
	logic                       flg_vfw_r;
	logic                       flg_vout_r;
	plr_pkg::plr_ov_state_e     st_r;
	plr_pkg::plr_ov_state_e     st_nxt;
	logic [15:0]                cyc_r;
	logic [15:0]                cyc_nxt;
	logic [2:0]                 rise_r;
	logic [2:0]                 rise_nxt;
	logic                       follower;
	logic                       ov_fault;
	logic                       req;
	logic                       is_off;
	logic                       is_on;
	logic                       is_cal;
	logic                       is_ov;
	logic                       known;
	logic [8:0]                 qtr;
	logic [6:0]                 qtr7;
	logic                       off_range_ok;
	logic                       on_range_ok;
	logic                       off_accept;
	logic                       on_accept;
	logic                       off_bad;
	logic                       on_bad;
	logic [2:0]                 ovr_rs_wr;
	logic                       ovr_rs_ok;
	logic                       ov_blocked;
	logic                       ovr_accept;
	logic                       ovr_bad;
	logic                       cal_accept;
	logic                       ivd_evt;
	logic                       ivc_evt;
	logic                       nack_nxt;
	logic                       ack_nxt;
	logic [15:0]                off_word;
	logic [15:0]                on_word;
	logic [15:0]                cal_word;
	logic [15:0]                ovr_word;
	logic [15:0]                rd_nxt;
	logic                       ov_shutdown;
	logic                       rise_done;
	logic                       cyc_done;
	logic                       retry_abort;
	logic                       ss_req_nxt;
	logic                       out_en_nxt;
	logic                       alert_nxt;
	logic [15:0]                nvm_nxt;
	logic [15:0]                rise_len;
	logic [10:0]                cal_mant;

	// ******************************************************************
	// Pin inputs
	// ******************************************************************
	plr_sync3 #(
		.W      (2)
	) u_sync (
		.i_clk  (I_CLK_SYS),
		.i_nrst (I_NRST),
		.i_d    ({I_LOOP_FOLLOWER, I_OV_FAULT}),
		.o_q    ({follower, ov_fault})
	);

	// ******************************************************************
	// Command decode
	// ******************************************************************
	assign req     = I_CMD_WR | I_CMD_RD;
	assign is_off  = (I_CMD_CODE == plr_pkg::CMD_INPUT_TURNOFF_THRESHOLD);
	assign is_on   = (I_CMD_CODE == plr_pkg::CMD_VIN_ON);
	assign is_cal  = (I_CMD_CODE == plr_pkg::CMD_IOUT_CAL);
	assign is_ov   = (I_CMD_CODE == plr_pkg::CMD_OV_RESPONSE);
	assign known   = is_off | is_on | is_cal | is_ov;

	// ******************************************************************
	// Threshold writes
	// ******************************************************************
	assign qtr  = plr_pkg::plr_to_quarters(I_WR_DATA);
	assign qtr7 = qtr[6:0];

	assign off_range_ok = !qtr[8] && !qtr[7] &&
		(qtr7 >= plr_pkg::INPUT_TURNOFF_THRESHOLD_MIN) && (qtr7 <= plr_pkg::INPUT_TURNOFF_THRESHOLD_MAX);
	assign on_range_ok  = !qtr[8] && !qtr[7] &&
		(qtr7 >= plr_pkg::VIN_ON_MIN) && (qtr7 <= plr_pkg::VIN_ON_MAX);

	assign off_accept = I_CMD_WR & is_off & off_range_ok & (qtr7 < vin_on_r);
	assign on_accept  = I_CMD_WR & is_on & on_range_ok & (qtr7 > input_turnoff_threshold_r);
	assign off_bad    = I_CMD_WR & is_off & ~off_accept;
	assign on_bad     = I_CMD_WR & is_on & ~on_accept;

	// ******************************************************************
	// Offset and response writes
	// ******************************************************************
	assign cal_accept = I_CMD_WR & is_cal;

	assign ovr_rs_wr  = I_WR_DATA[plr_pkg::OVR_RS_HI:plr_pkg::OVR_RS_LO];
	assign ovr_rs_ok  = (ovr_rs_wr == plr_pkg::OVR_RS_OFF) ||
		(ovr_rs_wr == plr_pkg::OVR_RS_ON);
	assign ov_blocked = follower & is_ov & req;
	assign ovr_accept = I_CMD_WR & is_ov & ~follower & ovr_rs_ok;
	assign ovr_bad    = I_CMD_WR & is_ov & ~follower & ~ovr_rs_ok;

	assign ivd_evt  = off_bad | on_bad | ovr_bad;
	assign nack_nxt = (req & ~known) | ov_blocked;
	assign ivc_evt  = nack_nxt;
	assign ack_nxt  = req & ~nack_nxt;

	// ******************************************************************
	// Read words
	// ******************************************************************
	assign off_word = {plr_pkg::VIN_EXP, plr_pkg::VIN_MANT_FIXED, input_turnoff_threshold_r};
	assign on_word  = {plr_pkg::VIN_EXP, plr_pkg::VIN_MANT_FIXED, vin_on_r};
	assign cal_mant = {cal_sign_r, {plr_pkg::CAL_EXT_W{cal_sign_r}}, cal_low_r};
	assign cal_word = {plr_pkg::CAL_EXP, cal_mant};
	assign ovr_word = {8'h00, ovr_sel_r, 1'b0, {3{ovr_rs5_r}}, {3{ovr_rs5_r}}};

	assign rd_nxt = is_off ? off_word :
		is_on  ? on_word  :
		is_cal ? cal_word :
		ovr_word;

	// ******************************************************************
	// Command registers
	// ******************************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			input_turnoff_threshold_r <= plr_pkg::INPUT_TURNOFF_THRESHOLD_RESET;
			vin_on_r  <= plr_pkg::VIN_ON_RESET;
		end else begin
			if (off_accept) begin
				input_turnoff_threshold_r <= qtr7;
			end
			if (on_accept) begin
				vin_on_r <= qtr7;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			cal_sign_r <= 1'b0;
			cal_low_r  <= plr_pkg::CAL_LOW_RESET;
		end else if (cal_accept) begin
			cal_sign_r <= I_WR_DATA[plr_pkg::CAL_SIGN_BIT];
			cal_low_r  <= I_WR_DATA[plr_pkg::CAL_LOW_W-1:0];
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			ovr_sel_r <= plr_pkg::OVR_SEL_RESET;
			ovr_rs5_r <= plr_pkg::OVR_RS5_RESET;
		end else if (ovr_accept) begin
			ovr_sel_r <= I_WR_DATA[plr_pkg::OVR_SEL_BIT];
			ovr_rs5_r <= I_WR_DATA[plr_pkg::OVR_RS_HI];
		end
	end

	// ******************************************************************
	// Command answer
	// ******************************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_CMD_ACK  <= 1'b0;
			O_CMD_NACK <= 1'b0;
			O_RD_DATA  <= 16'h0000;
		end else begin
			O_CMD_ACK  <= ack_nxt;
			O_CMD_NACK <= nack_nxt;
			if (I_CMD_RD && ack_nxt) begin
				O_RD_DATA <= rd_nxt;
			end
		end
	end

	// ******************************************************************
	// Sticky status flags, set wins over clear
	// ******************************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			flg_cml_r  <= 1'b0;
			flg_ivd_r  <= 1'b0;
			flg_ivc_r  <= 1'b0;
			flg_ovf_r  <= 1'b0;
			flg_vfw_r  <= 1'b0;
			flg_vout_r <= 1'b0;
		end else begin
			flg_cml_r  <= ivd_evt | ivc_evt | (flg_cml_r & ~I_CLEAR_FAULTS);
			flg_ivd_r  <= ivd_evt | (flg_ivd_r & ~I_CLEAR_FAULTS);
			flg_ivc_r  <= ivc_evt | (flg_ivc_r & ~I_CLEAR_FAULTS);
			flg_ovf_r  <= ov_fault | (flg_ovf_r & ~I_CLEAR_FAULTS);
			flg_vfw_r  <= ov_fault | (flg_vfw_r & ~I_CLEAR_FAULTS);
			flg_vout_r <= ov_fault | (flg_vout_r & ~I_CLEAR_FAULTS);
		end
	end

	assign alert_nxt = (flg_cml_r | flg_ivd_r | flg_ivc_r | flg_ovf_r | flg_vfw_r |
		flg_vout_r) & ~I_ALERT_MASK;

	// ******************************************************************
	// Overvoltage response sequencing
	// ******************************************************************
	assign ov_shutdown = ov_fault & ovr_sel_r;
	assign rise_len    = (I_TON_RISE_CYC == 16'h0000) ? 16'h0001 : I_TON_RISE_CYC;
	assign cyc_done    = (cyc_r + 16'h0001) >= rise_len;
	assign rise_done   = cyc_done && (rise_r == plr_pkg::RETRY_RISES - 3'h1);
	assign retry_abort = ~I_OP_ON | I_OTHER_FAULT;

	always_comb begin
		st_nxt     = st_r;
		cyc_nxt    = cyc_r;
		rise_nxt   = rise_r;
		ss_req_nxt = 1'b0;
		unique case (st_r)
			plr_pkg::OV_RUN: begin
				cyc_nxt  = 16'h0000;
				rise_nxt = 3'h0;
				if (ov_shutdown) begin
					st_nxt = ovr_rs5_r ? plr_pkg::OV_RETRY_WAIT : plr_pkg::OV_LATCHED;
				end
			end
			plr_pkg::OV_LATCHED: begin
				if (I_CLEAR_FAULTS && !ov_fault) begin
					st_nxt = plr_pkg::OV_RUN;
				end
			end
			plr_pkg::OV_RETRY_WAIT: begin
				if (retry_abort) begin
					st_nxt = plr_pkg::OV_LATCHED;
				end else if (rise_done) begin
					st_nxt     = plr_pkg::OV_RUN;
					ss_req_nxt = ~ov_shutdown;
				end else if (cyc_done) begin
					cyc_nxt  = 16'h0000;
					rise_nxt = rise_r + 3'h1;
				end else begin
					cyc_nxt = cyc_r + 16'h0001;
				end
			end
		endcase
	end

	assign out_en_nxt = (st_nxt == plr_pkg::OV_RUN) & I_OP_ON & ~ov_shutdown;

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			st_r   <= plr_pkg::OV_RUN;
			cyc_r  <= 16'h0000;
			rise_r <= 3'h0;
		end else begin
			st_r   <= st_nxt;
			cyc_r  <= cyc_nxt;
			rise_r <= rise_nxt;
		end
	end

	// ******************************************************************
	// Nonvolatile store image
	// ******************************************************************
	assign nvm_nxt = {ovr_sel_r, ovr_rs5_r, cal_sign_r, cal_low_r, input_turnoff_threshold_r};

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_NVM_WR   <= 1'b0;
			O_NVM_DATA <= 16'h0000;
		end else begin
			O_NVM_WR <= I_STORE_ALL;
			if (I_STORE_ALL) begin
				O_NVM_DATA <= nvm_nxt;
			end
		end
	end

	// ******************************************************************
	// Status and control outputs
	// ******************************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_STATUS_CML      <= 1'b0;
			O_STATUS_IVD      <= 1'b0;
			O_STATUS_IVC      <= 1'b0;
			O_STATUS_OVF      <= 1'b0;
			O_STATUS_VFW      <= 1'b0;
			O_STATUS_VOUT_OVF <= 1'b0;
			O_SMBALERT_OE     <= 1'b0;
			O_OUTPUT_EN       <= 1'b0;
			O_SOFTSTART_REQ   <= 1'b0;
		end else begin
			O_STATUS_CML      <= flg_cml_r;
			O_STATUS_IVD      <= flg_ivd_r;
			O_STATUS_IVC      <= flg_ivc_r;
			O_STATUS_OVF      <= flg_ovf_r;
			O_STATUS_VFW      <= flg_vfw_r;
			O_STATUS_VOUT_OVF <= flg_vout_r;
			O_SMBALERT_OE     <= alert_nxt;
			O_OUTPUT_EN       <= out_en_nxt;
			O_SOFTSTART_REQ   <= ss_req_nxt;
		end
	end

	// ******************************************************************
	// Offset correction of current readback and limits
	// ******************************************************************
	plr_cal_adder #(
		.N        (3)
	) u_cal (
		.i_clk    (I_CLK_SYS),
		.i_nrst   (I_NRST),
		.i_offset (cal_mant),
		.i_val    ({I_OC_WARN_LIM, I_OC_FAULT_LIM, I_IOUT_MEAS}),
		.o_val    ({O_OC_WARN_CORR, O_OC_FAULT_CORR, O_IOUT_CORR})
	);

endmodule : plr_top
`default_nettype wire

//--- plr_top_asserts.sv
// Assertions on the command, status and output ports
`timescale 1ns/10ps
`default_nettype none
module plr_top_asserts (
	input wire logic        I_CLK_SYS,
	input wire logic        I_NRST,
	input wire logic        I_CMD_WR,
	input wire logic        I_CMD_RD,
	input wire logic [7:0]  I_CMD_CODE,
	input wire logic [15:0] I_WR_DATA,
	input wire logic        I_CLEAR_FAULTS,
	input wire logic        I_STORE_ALL,
	input wire logic        I_OP_ON,
	input wire logic        I_ALERT_MASK,
	input wire logic        O_CMD_ACK,
	input wire logic        O_CMD_NACK,
	input wire logic        O_STATUS_CML,
	input wire logic        O_STATUS_IVD,
	input wire logic        O_STATUS_OVF,
	input wire logic        O_STATUS_VFW,
	input wire logic        O_STATUS_VOUT_OVF,
	input wire logic        O_SMBALERT_OE,
	input wire logic        O_OUTPUT_EN,
	input wire logic        O_SOFTSTART_REQ,
	input wire logic        O_NVM_WR
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);
	wire logic bad_off;
	assign bad_off = I_CMD_WR && I_CMD_CODE == 8'h36 && I_WR_DATA[15:7] == 9'h1e0
		&& I_WR_DATA[6:0] > 7'h1e;
	a_bad_off_flags: assert property (bad_off |=> ##1 O_STATUS_CML && O_STATUS_IVD)
		else $error("bad turn-off write not flagged");
	a_alert_on_flag: assert property (O_STATUS_IVD && !I_ALERT_MASK && !$past(I_ALERT_MASK)
		|-> O_SMBALERT_OE)
		else $error("alert missing with flag set");
	a_flags_sticky: assert property ($fell(O_STATUS_CML)
		|-> $past(I_CLEAR_FAULTS, 1) || $past(I_CLEAR_FAULTS, 2))
		else $error("flag dropped without clear");
	a_ov_flag_set: assert property ($rose(O_STATUS_OVF) |-> O_STATUS_VFW && O_STATUS_VOUT_OVF)
		else $error("overvoltage flags not together");
	a_cmd_answer: assert property (I_CMD_WR || I_CMD_RD |=> O_CMD_ACK != O_CMD_NACK)
		else $error("command not answered once");
	a_nvm_store: assert property (I_STORE_ALL |=> O_NVM_WR)
		else $error("store not written");
	a_restart_en: assert property (O_SOFTSTART_REQ |-> ##[0:1] O_OUTPUT_EN)
		else $error("restart without output on");
	a_cmd_off: assert property (!I_OP_ON |=> !O_OUTPUT_EN)
		else $error("output on while commanded off");
	c_nack: cover property (O_CMD_NACK);
	c_restart: cover property (O_SOFTSTART_REQ);
	c_store: cover property (O_NVM_WR);
endmodule : plr_top_asserts
bind plr_top plr_top_asserts plr_top_asserts_i (.*);
`default_nettype wire

//--- tb_plr_top.sv
// Self-checking bench for the threshold, offset and response commands
`timescale 1ns/10ps
`default_nettype none
module tb_plr_top;
	logic I_CLK_SYS = 1'b0, I_NRST = 1'b0, I_CMD_WR, I_CMD_RD, O_CMD_ACK, O_CMD_NACK;
	logic [7:0] I_CMD_CODE;
	logic [15:0] I_WR_DATA, O_RD_DATA, O_NVM_DATA, O_IOUT_CORR, O_OC_FAULT_CORR, O_OC_WARN_CORR;
	logic I_CLEAR_FAULTS = 1'b0, I_STORE_ALL = 1'b0, I_LOOP_FOLLOWER = 1'b0, I_OV_FAULT = 1'b0;
	logic I_OTHER_FAULT = 1'b0, I_OP_ON = 1'b1, I_ALERT_MASK = 1'b0;
	logic [15:0] I_TON_RISE_CYC = 16'h0004, I_IOUT_MEAS = 16'h0064, I_OC_FAULT_LIM = 16'h0028;
	logic [15:0] I_OC_WARN_LIM = 16'h0020, q;
	logic O_STATUS_CML, O_STATUS_IVD, O_STATUS_IVC, O_STATUS_OVF, O_STATUS_VFW, O_STATUS_VOUT_OVF;
	logic O_SMBALERT_OE, O_OUTPUT_EN, O_SOFTSTART_REQ, O_NVM_WR;
	logic [1:0] an;
	int num_errors = 0, samples_checked = 0, cyc = 0, n;
	always #10 I_CLK_SYS = ~I_CLK_SYS;
	plr_top plr_top_i (.*);
	plr_host plr_host_i (.i_clk(I_CLK_SYS), .i_ack(O_CMD_ACK), .i_nack(O_CMD_NACK),
		.i_rd(O_RD_DATA), .o_wr(I_CMD_WR), .o_rd(I_CMD_RD), .o_code(I_CMD_CODE),
		.o_data(I_WR_DATA));
	task automatic close_out;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_bit(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge I_CLK_SYS);
			n++;
		end
		chk({15'h0, s}, {15'h0, v});
	endtask : wait_bit
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		plr_host_i.xfer(1'b1, c, d, an, q);
	endtask : wr
	task automatic rd(input logic [7:0] c);
		plr_host_i.xfer(1'b0, c, 16'h0000, an, q);
	endtask : rd
	task automatic pulse;
		I_CLEAR_FAULTS <= 1'b1;
		@(posedge I_CLK_SYS);
		I_CLEAR_FAULTS <= 1'b0;
		@(posedge I_CLK_SYS);
	endtask : pulse
	task automatic t_defaults;
		rd(8'h36);
		chk(q, 16'hf010);
		rd(8'h35);
		chk(q, 16'hf012);
		rd(8'h39);
		chk(q, 16'he000);
		rd(8'h41);
		chk(q, 16'h00bf);
	endtask : t_defaults
	task automatic t_off;
		wr(8'h36, 16'he821);
		rd(8'h36);
		chk(q, 16'hf011);
		wr(8'h36, 16'hf040);
		chk({14'h0, an}, 16'h0002);
		rd(8'h36);
		chk(q, 16'hf011);
		chk({14'h0, O_STATUS_CML, O_STATUS_IVD}, 16'h0003);
		chk({15'h0, O_SMBALERT_OE}, 16'h0001);
		pulse;
		wr(8'h36, 16'hf012);
		rd(8'h36);
		chk(q, 16'hf011);
		chk({15'h0, O_STATUS_IVD}, 16'h0001);
		wr(8'h35, 16'hf014);
		rd(8'h35);
		chk(q, 16'hf014);
		rd(8'h00);
		chk({14'h0, an}, 16'h0001);
		pulse;
	endtask : t_off
	task automatic t_cal;
		wr(8'h39, 16'h07ff);
		rd(8'h39);
		chk(q, 16'he7ff);
		wait_bit(O_OUTPUT_EN, 1'b1, 4);
		repeat (6) @(posedge I_CLK_SYS);
		chk(O_IOUT_CORR, 16'h0063);
		chk(O_OC_FAULT_CORR, 16'h0027);
		chk(O_OC_WARN_CORR, 16'h001f);
		I_STORE_ALL <= 1'b1;
		@(posedge I_CLK_SYS);
		I_STORE_ALL <= 1'b0;
		@(posedge I_CLK_SYS);
		chk({15'h0, O_NVM_WR}, 16'h0001);
		chk(O_NVM_DATA, 16'hff91);
		wr(8'h39, 16'h0040);
		rd(8'h39);
		chk(q, 16'he000);
	endtask : t_cal
	task automatic t_resp;
		wr(8'h41, 16'h0090);
		rd(8'h41);
		chk(q, 16'h00bf);
		chk({15'h0, O_STATUS_IVD}, 16'h0001);
		pulse;
		wr(8'h41, 16'h00b8);
		rd(8'h41);
		chk(q, 16'h00bf);
		wr(8'h41, 16'h0080);
		rd(8'h41);
		chk(q, 16'h0080);
	endtask : t_resp
	task automatic t_latch;
		I_OV_FAULT <= 1'b1;
		wait_bit(O_OUTPUT_EN, 1'b0, 20);
		@(posedge I_CLK_SYS);
		chk({13'h0, O_STATUS_OVF, O_STATUS_VFW, O_STATUS_VOUT_OVF}, 16'h0007);
		I_OV_FAULT <= 1'b0;
		repeat (60) @(posedge I_CLK_SYS);
		chk({15'h0, O_OUTPUT_EN}, 16'h0000);
		pulse;
		wait_bit(O_OUTPUT_EN, 1'b1, 10);
	endtask : t_latch
	task automatic t_retry;
		wr(8'h41, 16'h00bf);
		I_OV_FAULT <= 1'b1;
		wait_bit(O_OUTPUT_EN, 1'b0, 20);
		I_OV_FAULT <= 1'b0;
		wait_bit(O_SOFTSTART_REQ, 1'b1, 60);
		chk({15'h0, n >= 28 && n <= 36}, 16'h0001);
		wait_bit(O_OUTPUT_EN, 1'b1, 4);
		I_OV_FAULT <= 1'b1;
		I_OTHER_FAULT <= 1'b1;
		wait_bit(O_OUTPUT_EN, 1'b0, 20);
		I_OV_FAULT <= 1'b0;
		repeat (40) @(posedge I_CLK_SYS);
		chk({15'h0, O_OUTPUT_EN}, 16'h0000);
		I_OTHER_FAULT <= 1'b0;
		pulse;
	endtask : t_retry
	task automatic t_ignore;
		wr(8'h41, 16'h0000);
		I_OV_FAULT <= 1'b1;
		wait_bit(O_STATUS_OVF, 1'b1, 20);
		chk({14'h0, O_OUTPUT_EN, O_SMBALERT_OE}, 16'h0003);
		I_ALERT_MASK <= 1'b1;
		repeat (2) @(posedge I_CLK_SYS);
		chk({15'h0, O_SMBALERT_OE}, 16'h0000);
		I_ALERT_MASK <= 1'b0;
		I_OV_FAULT <= 1'b0;
		repeat (8) @(posedge I_CLK_SYS);
		pulse;
	endtask : t_ignore
	task automatic t_follower;
		I_LOOP_FOLLOWER <= 1'b1;
		repeat (8) @(posedge I_CLK_SYS);
		rd(8'h41);
		chk({14'h0, an}, 16'h0001);
		wr(8'h41, 16'h00bf);
		chk({14'h0, an}, 16'h0001);
		chk({15'h0, O_STATUS_IVC}, 16'h0001);
		I_LOOP_FOLLOWER <= 1'b0;
		repeat (8) @(posedge I_CLK_SYS);
		rd(8'h41);
		chk(q, 16'h0000);
		I_OP_ON <= 1'b0;
		wait_bit(O_OUTPUT_EN, 1'b0, 4);
	endtask : t_follower
	always @(posedge I_CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		repeat (16) @(posedge I_CLK_SYS);
		I_NRST <= 1'b1;
		@(posedge I_CLK_SYS);
		t_defaults;
		t_off;
		t_cal;
		t_resp;
		t_latch;
		t_retry;
		t_ignore;
		t_follower;
		close_out;
	end
endmodule : tb_plr_top
`default_nettype wire
